// [logic/shift_move_indirect_pkg.sv]
package shift_move_indirect_pkg;

  // Operation codes on OP_CODE; code 3 is not a valid operation
  localparam logic [1:0] OP_SHIFT = 2'h0;
  localparam logic [1:0] OP_MOVE  = 2'h1;
  localparam logic [1:0] OP_IND   = 2'h2;
  localparam logic [1:0] OP_NONE  = 2'h3;

  // Pointer update modes
  localparam logic [1:0] MODE_PRE_INC  = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  // Direct file addresses that are indirect windows
  localparam logic [6:0] WIN0_ADDR = 7'h00;
  localparam logic [6:0] WIN1_ADDR = 7'h01;

  // Register port offsets
  localparam logic [2:0] REG_W     = 3'h0;
  localparam logic [2:0] REG_STAT  = 3'h1;
  localparam logic [2:0] REG_P0_LO = 3'h2;
  localparam logic [2:0] REG_P0_HI = 3'h3;
  localparam logic [2:0] REG_P1_LO = 3'h4;
  localparam logic [2:0] REG_P1_HI = 3'h5;

  // Status field positions
  localparam int STAT_C_BIT = 0;
  localparam int STAT_Z_BIT = 2;

  // Reset values and the pointer step
  localparam logic [7:0]  W_RESET   = 8'h00;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [15:0] PTR_ONE   = 16'h0001;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } state_t;

  typedef struct packed {
    state_t      state;
    logic [7:0]  w;
    logic        c;
    logic        z;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [1:0]  op;
    logic        dest;
    logic [15:0] ea;
    logic        done;
    logic        wr_en;
    logic [15:0] wr_addr;
    logic [7:0]  wr_data;
    logic [7:0]  bus_rdata;
  } exec_st_t;

  localparam exec_st_t ST_RESET = '{
    state:     ST_IDLE,
    w:         W_RESET,
    c:         1'b0,
    z:         1'b0,
    ptr0:      PTR_RESET,
    ptr1:      PTR_RESET,
    op:        OP_NONE,
    dest:      1'b0,
    ea:        PTR_RESET,
    done:      1'b0,
    wr_en:     1'b0,
    wr_addr:   PTR_RESET,
    wr_data:   BYTE_ZERO,
    bus_rdata: BYTE_ZERO
  };

endpackage

// [logic/shift_move_indirect_exec.sv]
// What this block does
// - Register 0..127 shifts one bit right into carry; C and Z updated.
// - Shift result MSB is zero; source LSB goes into carry.
// - Shift destination 0 writes accumulator, 1 writes source back.
// - Move copies register to accumulator for 0, back to itself for 1.
// - Move always updates zero flag, even when writing back to itself.
// - Indirect load copies pointed-to register into accumulator; updates Z.
// - Mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec pointer.
// - Relative form addresses pointer plus signed -32..31; pointer kept.
// - After access pointer is plus one, minus one, or unchanged.
// - Indirect window has no storage; access goes to pointer's address.
// - Pointer is 16 bits and wraps at both ends.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
module shift_move_indirect_exec
  import shift_move_indirect_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  input  wire logic        OP_VALID,
  input  wire logic [1:0]  OP_CODE,
  input  wire logic [6:0]  FILE_ADDR,
  input  wire logic        DEST_SEL,
  input  wire logic        PTR_SEL,
  input  wire logic        REL_FORM,
  input  wire logic [1:0]  PTR_MODE,
  input  wire logic [5:0]  REL_OFFSET,
  output logic             OP_READY,
  output logic             OP_DONE,
  output logic [15:0]      RF_RADDR,
  input  wire logic [7:0]  RF_RDATA,
  output logic             RF_WE,
  output logic [15:0]      RF_WADDR,
  output logic [7:0]       RF_WDATA,
  output logic [7:0]       W_OUT,
  output logic             CARRY,
  output logic             ZERO,
  output logic [15:0]      PTR0_OUT,
  output logic [15:0]      PTR1_OUT,
  input  wire logic [2:0]  BUS_ADDR,
  input  wire logic [7:0]  BUS_WDATA,
  input  wire logic        BUS_WE,
  input  wire logic        BUS_RE,
  output logic [7:0]       BUS_RDATA
);

  exec_st_t s_q;
  exec_st_t s_d;
  logic     accept;
  logic     rd_lsb;

  assign accept   = OP_READY && OP_VALID && (OP_CODE != OP_NONE);
  assign rd_lsb   = RF_RDATA[0];
  assign OP_READY = (s_q.state == ST_IDLE);
  assign OP_DONE  = s_q.done;
  assign RF_RADDR = s_q.ea;
  assign RF_WE    = s_q.wr_en;
  assign RF_WADDR = s_q.wr_addr;
  assign RF_WDATA = s_q.wr_data;
  assign W_OUT    = s_q.w;
  assign CARRY    = s_q.c;
  assign ZERO     = s_q.z;
  assign PTR0_OUT = s_q.ptr0;
  assign PTR1_OUT = s_q.ptr1;
  assign BUS_RDATA = s_q.bus_rdata;

  always_comb begin
    logic [15:0] cur;
    logic [15:0] nxt;
    logic [15:0] offs;
    logic [7:0]  res;
    logic [7:0]  stat;
    cur  = PTR_SEL ? s_q.ptr1 : s_q.ptr0;
    nxt  = cur;
    offs = {{10{REL_OFFSET[5]}}, REL_OFFSET};
    res  = RF_RDATA;
    stat = BYTE_ZERO;
    stat[STAT_C_BIT] = s_q.c;
    stat[STAT_Z_BIT] = s_q.z;
    s_d = s_q;
    s_d.done  = 1'b0;
    s_d.wr_en = 1'b0;

    // Software writes first, so a same-cycle operation result wins
    if (BUS_WE) begin
      if (BUS_ADDR == REG_W) begin
        s_d.w = BUS_WDATA;
      end else if (BUS_ADDR == REG_STAT) begin
        s_d.c = BUS_WDATA[STAT_C_BIT];
        s_d.z = BUS_WDATA[STAT_Z_BIT];
      end else if (BUS_ADDR == REG_P0_LO) begin
        s_d.ptr0[7:0] = BUS_WDATA;
      end else if (BUS_ADDR == REG_P0_HI) begin
        s_d.ptr0[15:8] = BUS_WDATA;
      end else if (BUS_ADDR == REG_P1_LO) begin
        s_d.ptr1[7:0] = BUS_WDATA;
      end else if (BUS_ADDR == REG_P1_HI) begin
        s_d.ptr1[15:8] = BUS_WDATA;
      end
    end

    // Read data stands for exactly one cycle; unmapped reads give zero
    s_d.bus_rdata = BYTE_ZERO;
    if (BUS_RE) begin
      if (BUS_ADDR == REG_W) begin
        s_d.bus_rdata = s_q.w;
      end else if (BUS_ADDR == REG_STAT) begin
        s_d.bus_rdata = stat;
      end else if (BUS_ADDR == REG_P0_LO) begin
        s_d.bus_rdata = s_q.ptr0[7:0];
      end else if (BUS_ADDR == REG_P0_HI) begin
        s_d.bus_rdata = s_q.ptr0[15:8];
      end else if (BUS_ADDR == REG_P1_LO) begin
        s_d.bus_rdata = s_q.ptr1[7:0];
      end else if (BUS_ADDR == REG_P1_HI) begin
        s_d.bus_rdata = s_q.ptr1[15:8];
      end
    end

    case (s_q.state)
      ST_IDLE: begin
        if (accept) begin
          s_d.op    = OP_CODE;
          s_d.dest  = DEST_SEL;
          s_d.state = ST_EXEC;
          if (OP_CODE == OP_IND) begin
            if (REL_FORM) begin
              s_d.ea = cur + offs;
            end else begin
              // Pointer arithmetic is 16 bits and wraps naturally
              case (PTR_MODE)
                MODE_PRE_INC: begin
                  nxt    = cur + PTR_ONE;
                  s_d.ea = nxt;
                end
                MODE_PRE_DEC: begin
                  nxt    = cur - PTR_ONE;
                  s_d.ea = nxt;
                end
                MODE_POST_INC: begin
                  nxt    = cur + PTR_ONE;
                  s_d.ea = cur;
                end
                default: begin
                  nxt    = cur - PTR_ONE;
                  s_d.ea = cur;
                end
              endcase
            end
            // Pointer settles during accept; op beats a same-cycle bus write
            if (PTR_SEL) begin
              s_d.ptr1 = nxt;
            end else begin
              s_d.ptr0 = nxt;
            end
          end else if (FILE_ADDR == WIN0_ADDR) begin
            s_d.ea = s_q.ptr0;
          end else if (FILE_ADDR == WIN1_ADDR) begin
            s_d.ea = s_q.ptr1;
          end else begin
            s_d.ea = {9'h000, FILE_ADDR};
          end
        end
      end
      ST_EXEC: begin
        if (s_q.op == OP_SHIFT) begin
          res   = {1'b0, RF_RDATA[7:1]};
          s_d.c = RF_RDATA[0];
        end
        s_d.z = (res == BYTE_ZERO);
        if (s_q.op == OP_IND || !s_q.dest) begin
          s_d.w = res;
        end else begin
          s_d.wr_en   = 1'b1;
          s_d.wr_addr = s_q.ea;
          s_d.wr_data = res;
        end
        s_d.done  = 1'b1;
        s_d.state = ST_IDLE;
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      s_q <= ST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  property p_exec_len;
    accept |=> (s_q.state == ST_EXEC) ##1 OP_DONE;
  endproperty
  a_exec_len: assert property (p_exec_len)
    else $error("operation did not finish two cycles after accept");

  property p_shift_w;
    (OP_DONE && s_q.op == OP_SHIFT && !s_q.dest)
      |-> (W_OUT == ($past(RF_RDATA) >> 1)) && !RF_WE;
  endproperty
  a_shift_w: assert property (p_shift_w)
    else $error("shift to accumulator gave wrong value");

  property p_shift_c;
    (OP_DONE && s_q.op == OP_SHIFT)
      |-> (CARRY == $past(rd_lsb))
          && (RF_WE ? !RF_WDATA[7] : !W_OUT[7]);
  endproperty
  a_shift_c: assert property (p_shift_c)
    else $error("shift carry or msb wrong");

  property p_shift_wb;
    (OP_DONE && s_q.op == OP_SHIFT && s_q.dest)
      |-> RF_WE && RF_WADDR == s_q.ea
          && RF_WDATA == ($past(RF_RDATA) >> 1);
  endproperty
  a_shift_wb: assert property (p_shift_wb)
    else $error("shift write-back wrong");

  property p_shift_z;
    (OP_DONE && s_q.op == OP_SHIFT)
      |-> ZERO == ($past(RF_RDATA[7:1]) == 7'h00);
  endproperty
  a_shift_z: assert property (p_shift_z)
    else $error("shift zero flag wrong");

  property p_move_z;
    (OP_DONE && s_q.op == OP_MOVE)
      |-> ZERO == ($past(RF_RDATA) == BYTE_ZERO);
  endproperty
  a_move_z: assert property (p_move_z)
    else $error("move did not update zero flag");

  property p_move_w;
    (OP_DONE && s_q.op == OP_MOVE && !s_q.dest)
      |-> W_OUT == $past(RF_RDATA);
  endproperty
  a_move_w: assert property (p_move_w)
    else $error("move to accumulator wrong");

  property p_move_wb;
    (OP_DONE && s_q.op == OP_MOVE && s_q.dest)
      |-> RF_WE && RF_WADDR == s_q.ea && RF_WDATA == $past(RF_RDATA);
  endproperty
  a_move_wb: assert property (p_move_wb)
    else $error("move write-back wrong");

  property p_ind_w;
    (OP_DONE && s_q.op == OP_IND)
      |-> W_OUT == $past(RF_RDATA) && ZERO == (W_OUT == BYTE_ZERO);
  endproperty
  a_ind_w: assert property (p_ind_w)
    else $error("indirect load result or zero flag wrong");

  property p_ind_no_wr;
    (OP_DONE && s_q.op == OP_IND) |-> !RF_WE;
  endproperty
  a_ind_no_wr: assert property (p_ind_no_wr)
    else $error("indirect load wrote the register file");

  property p_pre_inc;
    (accept && OP_CODE == OP_IND && !REL_FORM && !PTR_SEL
      && PTR_MODE == MODE_PRE_INC)
      |=> s_q.ptr0 == $past(s_q.ptr0) + PTR_ONE && s_q.ea == s_q.ptr0;
  endproperty
  a_pre_inc: assert property (p_pre_inc)
    else $error("pre-increment wrong");

  property p_post_dec;
    (accept && OP_CODE == OP_IND && !REL_FORM && PTR_SEL
      && PTR_MODE == MODE_POST_DEC)
      |=> s_q.ptr1 == $past(s_q.ptr1) - PTR_ONE && s_q.ea == $past(s_q.ptr1);
  endproperty
  a_post_dec: assert property (p_post_dec)
    else $error("post-decrement wrong");

  property p_rel;
    (accept && OP_CODE == OP_IND && REL_FORM && !PTR_SEL)
      |=> s_q.ptr0 == $past(s_q.ptr0)
          && s_q.ea == $past(s_q.ptr0) + {{10{$past(REL_OFFSET[5])}},
                                          $past(REL_OFFSET)};
  endproperty
  a_rel: assert property (p_rel)
    else $error("relative offset address wrong");

  property p_wrap;
    (accept && OP_CODE == OP_IND && !REL_FORM && PTR_SEL
      && PTR_MODE == MODE_PRE_INC && (&s_q.ptr1))
      |=> s_q.ptr1 == PTR_RESET && s_q.ea == PTR_RESET;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pointer did not wrap to zero");

  property p_window;
    (accept && OP_CODE != OP_IND && FILE_ADDR == WIN1_ADDR)
      |=> s_q.ea == $past(s_q.ptr1);
  endproperty
  a_window: assert property (p_window)
    else $error("window access not redirected");

endmodule

// [bench/shift_move_indirect_exec_tb_top.sv]
`timescale 1ns/1ps
module shift_move_indirect_exec_tb_top;
  import shift_move_indirect_pkg::*;
  logic        SYS_CLK, RST_B, OP_VALID, DEST_SEL, PTR_SEL, REL_FORM;
  logic        BUS_WE, BUS_RE, OP_READY, OP_DONE, RF_WE, CARRY, ZERO;
  logic [1:0]  OP_CODE, PTR_MODE;
  logic [6:0]  FILE_ADDR;
  logic [5:0]  REL_OFFSET;
  logic [2:0]  BUS_ADDR;
  logic [7:0]  RF_RDATA, RF_WDATA, W_OUT, BUS_WDATA, BUS_RDATA, got;
  logic [15:0] RF_RADDR, RF_WADDR, PTR0_OUT, PTR1_OUT, p, np, ea;
  int          error_cnt = 0;
  int          comparisons = 0;

  shift_move_indirect_exec dut_u (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .OP_VALID(OP_VALID),
    .OP_CODE(OP_CODE), .FILE_ADDR(FILE_ADDR), .DEST_SEL(DEST_SEL),
    .PTR_SEL(PTR_SEL), .REL_FORM(REL_FORM), .PTR_MODE(PTR_MODE),
    .REL_OFFSET(REL_OFFSET), .OP_READY(OP_READY), .OP_DONE(OP_DONE),
    .RF_RADDR(RF_RADDR), .RF_RDATA(RF_RDATA), .RF_WE(RF_WE),
    .RF_WADDR(RF_WADDR), .RF_WDATA(RF_WDATA), .W_OUT(W_OUT),
    .CARRY(CARRY), .ZERO(ZERO), .PTR0_OUT(PTR0_OUT), .PTR1_OUT(PTR1_OUT),
    .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_WE(BUS_WE),
    .BUS_RE(BUS_RE), .BUS_RDATA(BUS_RDATA)
  );

  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e,
                     input string what);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask

  task automatic finish_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    BUS_WE    <= 1'b1;
    BUS_ADDR  <= a;
    BUS_WDATA <= d;
    @(posedge SYS_CLK);
    BUS_WE <= 1'b0;
  endtask

  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge SYS_CLK);
    BUS_RE   <= 1'b1;
    BUS_ADDR <= a;
    @(posedge SYS_CLK);
    BUS_RE <= 1'b0;
    #1;
    d = BUS_RDATA;
  endtask

  // Returns one step into the done cycle so one-cycle outputs can be seen
  task automatic do_op(input logic [1:0] code, input logic [6:0] fa,
                       input logic d, input logic ps, input logic rel,
                       input logic [1:0] md, input logic [5:0] off,
                       input logic [7:0] data, input logic [15:0] exp_ea);
    @(posedge SYS_CLK);
    OP_VALID   <= 1'b1;
    OP_CODE    <= code;
    FILE_ADDR  <= fa;
    DEST_SEL   <= d;
    PTR_SEL    <= ps;
    REL_FORM   <= rel;
    PTR_MODE   <= md;
    REL_OFFSET <= off;
    RF_RDATA   <= data;
    @(posedge SYS_CLK);
    OP_VALID <= 1'b0;
    #1;
    chk(OP_READY, 1'b0, "busy");
    chk(RF_RADDR, exp_ea, "read address");
    @(posedge SYS_CLK);
    #1;
    chk(OP_DONE, 1'b1, "done");
  endtask

  task automatic t_reset_bus;
    chk(W_OUT, 8'h00, "w reset");
    chk(PTR0_OUT, 16'h0000, "ptr reset");
    bus_wr(3'h6, 8'h55);
    bus_rd(3'h6, got);
    chk(got, 8'h00, "unmapped read");
    bus_wr(REG_W, 8'hA5);
    bus_rd(REG_W, got);
    chk(got, 8'hA5, "w readback");
  endtask

  task automatic t_shift;
    do_op(OP_SHIFT, 7'h05, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 8'h81, 16'h0005);
    chk(W_OUT, 8'h40, "shift w");
    chk(CARRY, 1'b1, "shift c");
    chk(RF_WE, 1'b0, "shift no write");
    do_op(OP_SHIFT, 7'h7F, 1'b1, 1'b0, 1'b0, 2'h0, 6'h00, 8'h01, 16'h007F);
    chk(RF_WE, 1'b1, "shift write");
    chk(RF_WADDR, 16'h007F, "shift waddr");
    chk(RF_WDATA, 8'h00, "shift wdata");
    chk(ZERO, 1'b1, "shift z");
    chk(W_OUT, 8'h40, "w kept");
    do_op(OP_SHIFT, 7'h06, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 8'hFE, 16'h0006);
    chk({W_OUT, 6'h00, CARRY, ZERO}, 16'h7F00, "shift msb c z");
  endtask

  task automatic t_move;
    do_op(OP_MOVE, 7'h20, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 8'h00, 16'h0020);
    chk({W_OUT, 6'h00, CARRY, ZERO}, 16'h0001, "move w z");
    do_op(OP_MOVE, 7'h21, 1'b1, 1'b0, 1'b0, 2'h0, 6'h00, 8'h3C, 16'h0021);
    chk({RF_WE, RF_WDATA}, 16'h013C, "move write");
    chk(ZERO, 1'b0, "move z self");
    chk(W_OUT, 8'h00, "move w kept");
  endtask

  task automatic t_indirect;
    bus_wr(REG_P0_LO, 8'h00);
    bus_wr(REG_P0_HI, 8'h10);
    p = 16'h1000;
    for (int m = 0; m < 4; m++) begin
      ea = (m == 0) ? p + 16'h1 : (m == 1) ? p - 16'h1 : p;
      np = m[0] ? p - 16'h1 : p + 16'h1;
      do_op(OP_IND, 7'h00, 1'b0, 1'b0, 1'b0, m[1:0], 6'h00,
            8'(m * 16), ea);
      chk({RF_WE, W_OUT}, {8'h00, 8'(m * 16)}, "ind w");
      chk(ZERO, m == 0, "ind z");
      chk(PTR0_OUT, np, "ptr after");
      p = np;
    end
    do_op(OP_IND, 7'h00, 1'b0, 1'b0, 1'b1, 2'h0, 6'h20, 8'h77, p - 16'd32);
    chk(PTR0_OUT, p, "rel ptr kept");
    do_op(OP_IND, 7'h00, 1'b0, 1'b0, 1'b1, 2'h3, 6'h1F, 8'h00, p + 16'd31);
    chk({PTR0_OUT[7:0], W_OUT}, {p[7:0], 8'h00}, "rel w");
    bus_wr(REG_P1_LO, 8'hFF);
    bus_wr(REG_P1_HI, 8'hFF);
    do_op(OP_IND, 7'h00, 1'b0, 1'b1, 1'b0, MODE_PRE_INC, 6'h00, 8'h09, 16'h0000);
    chk(PTR1_OUT, 16'h0000, "wrap up");
    do_op(OP_IND, 7'h00, 1'b0, 1'b1, 1'b0, MODE_POST_DEC, 6'h00, 8'h09, 16'h0000);
    chk(PTR1_OUT, 16'hFFFF, "wrap down");
    bus_rd(REG_P1_HI, got);
    chk(got, 8'hFF, "ptr hi read");
  endtask

  task automatic t_window;
    do_op(OP_SHIFT, WIN0_ADDR, 1'b1, 1'b1, 1'b0, 2'h0, 6'h00, 8'h02,
          16'h1000);
    chk(RF_WADDR, 16'h1000, "window0 write");
    do_op(OP_MOVE, WIN1_ADDR, 1'b1, 1'b0, 1'b0, 2'h0, 6'h00, 8'h00, 16'hFFFF);
    chk(RF_WADDR, 16'hFFFF, "window write");
    chk(PTR1_OUT, 16'hFFFF, "window ptr");
    bus_rd(REG_STAT, got);
    chk(got, 8'h04, "status");
  endtask

  task automatic t_refused;
    @(posedge SYS_CLK);
    OP_VALID <= 1'b1;
    OP_CODE  <= OP_NONE;
    repeat (3) begin
      @(posedge SYS_CLK);
      #1;
      chk({OP_READY, OP_DONE}, 2'b10, "code 3 ignored");
    end
    @(posedge SYS_CLK);
    OP_VALID <= 1'b0;
  endtask

  initial begin
    repeat (2000) @(posedge SYS_CLK);
    error_cnt++;
    finish_test();
  end

  initial begin
    {RST_B, OP_VALID, DEST_SEL, PTR_SEL, REL_FORM, BUS_WE, BUS_RE} = '0;
    {OP_CODE, PTR_MODE, FILE_ADDR, REL_OFFSET, BUS_ADDR} = '0;
    {RF_RDATA, BUS_WDATA} = '0;
    repeat (6) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    t_reset_bus();
    t_shift();
    t_move();
    t_indirect();
    t_window();
    t_refused();
    finish_test();
  end
endmodule
